// ---- design/mbs_map.vh ----
// Constants of the register server: offsets, fields, reset values, counts.
// Assumes inclusion by every design file of the server; definitions only.
// Function
// RULE_01: Never close the connection whose peer equals the privileged client address.
// RULE_02: Timeout setting counts units of 500 ms each.
// RULE_03: Supervise only the privileged client; address zero disables supervision.
// RULE_04: Requests are accepted on server port 502 only.
// RULE_05: Configured unit id goes here; unit 255 goes to the embedded server.
// RULE_06: Client-written word count n is configurable up to 240 words of 16 bits.
// RULE_07: Client-read word count m is configurable up to 240 words of 16 bits.
// RULE_08: Client-written words sit at addresses 0 to n-1, read and write.
// RULE_09: Client-read words sit at addresses n to n+m-1, read only.
// RULE_10: Function 3 returns requested registers from either array.
// RULE_11: Functions 6 and 16 write only the client-written array.
// RULE_12: Function 23 writes client-written words then reads either array.
// RULE_13: Only functions 3, 6, 16 and 23 are supported.
// RULE_14: Access above n+m-1 answers exception 02 without any access.
// RULE_15: Both arrays refresh together as one snapshot on each task tick.
// RULE_16: Tick source selects parent cycle by default, or the main task.
// RULE_17: No privileged request within the timeout sets the lost flag.
// RULE_18: Beyond 8 connections, close non-privileged ones; keep the privileged one (code closes from 8 active connections on).
// RULE_19: Privileged requests restart the timer and clear the lost flag.
// RULE_20: Unsupported functions answer illegal function and change nothing.
`ifndef MBS_MAP_VH
`define MBS_MAP_VH
// ==========================================================
// Register map, byte addresses
`define MBS_REG_CTRL      12'h000
`define MBS_REG_PRIV_ADDR 12'h004
`define MBS_REG_TIMEOUT   12'h008
`define MBS_REG_UNIT      12'h00c
`define MBS_REG_COUNTS    12'h010
`define MBS_REG_STATUS    12'h014
`define MBS_REG_PORT      12'h018
// Control fields
`define MBS_CTRL_TICKSEL  0
`define MBS_CTRL_ENABLE   1
// Count fields
`define MBS_CNT_N_LSB     0
`define MBS_CNT_M_LSB     8
// ==========================================================
// Reset values
`define MBS_RST_CTRL      2'h2
`define MBS_RST_UNIT      8'h01
`define MBS_RST_N         8'hf0
`define MBS_RST_M         8'hf0
`define MBS_RST_TIMEOUT   16'h000a
// ==========================================================
// Protocol constants
`define MBS_PORT          16'h01f6
`define MBS_UNIT_EMB      8'hff
`define MBS_FC_RD         8'h03
`define MBS_FC_WR1        8'h06
`define MBS_FC_WRN        8'h10
`define MBS_FC_RW         8'h17
`define MBS_EX_FUNC       8'h01
`define MBS_EX_ADDR       8'h02
`define MBS_MAX_WORDS     240
`define MBS_MAX_CONN      8
// ==========================================================
// Timing
`define MBS_CLK_HZ        50000000
`define MBS_TO_UNIT_MS    500
`define MBS_TO_UNIT_CYC   ((`MBS_CLK_HZ / 1000) * `MBS_TO_UNIT_MS)
`endif

// ---- design/mbs_tick_div.v ----
// Timeout time base: one-cycle pulse per 500 ms unit.
// Assumes one clock aclk and synchronous active-low reset.
`include "mbs_map.vh"
`default_nettype none
module mbs_tick_div #(
  parameter integer DIV = `MBS_TO_UNIT_CYC
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Control
  input  wire clr,
  // Pulse
  output reg  tick_ff
);
  reg [31:0] cnt_ff;
  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == DIV - 1) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b1; // RULE_02
    end else begin
      cnt_ff  <= cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- design/mbs_server.v ----
// Register server: decodes parsed Modbus TCP requests onto two word arrays.
// Assumes a front end that parses frames to fields and serialises the answer.
`include "mbs_map.vh"
`default_nettype none
module mbs_server #(
  parameter integer TO_DIV = `MBS_TO_UNIT_CYC
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Parsed request
  input  wire        req_valid,
  input  wire [15:0] req_port,
  input  wire [7:0]  req_unit,
  input  wire [31:0] req_peer,
  input  wire [7:0]  req_func,
  input  wire [7:0]  req_rd_addr,
  input  wire [7:0]  req_rd_qty,
  input  wire [7:0]  req_wr_addr,
  input  wire [7:0]  req_wr_qty,
  input  wire [15:0] req_wr_data,
  // Answer word stream
  output reg         rsp_valid_ff,
  output reg         rsp_exc_ff,
  output reg  [7:0]  rsp_code_ff,
  output reg         rsp_word_valid_ff,
  output reg  [15:0] rsp_word_ff,
  output reg         rsp_done_ff,
  output reg         emb_route_ff,
  // Connection reclaim
  input  wire        conn_reclaim,
  input  wire [3:0]  conn_active,
  input  wire [31:0] conn_peer,
  output reg         conn_close_ff,
  // Application side
  input  wire        parent_tick,
  input  wire        main_task_tick,
  input  wire [3839:0] app_read_words,
  output reg  [3839:0] app_written_words_ff,
  output reg         privileged_client_lost_flag_ff
);
  localparam W = 16;
  localparam ST_IDLE = 3'b001;
  localparam ST_WR   = 3'b010;
  localparam ST_RD   = 3'b100;
  // ==========================================================
  // Configuration registers
  reg  [1:0]  ctrl_ff;
  reg  [31:0] privileged_client_address_ff;
  reg  [15:0] timeout_ff;
  reg  [7:0]  unit_ff;
  reg  [7:0]  n_ff;
  reg  [7:0]  m_ff;
  reg  [11:0] awaddr_ff;
  reg         aw_ok_ff;
  reg  [31:0] wdata_ff;
  reg         w_ok_ff;
  reg  [15:0] to_cnt_ff;
  reg  [3:0]  rd_cnt_ff;
  wire        wr_fire = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  wire        tick_sel = ctrl_ff[`MBS_CTRL_TICKSEL];
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_ok_ff      <= 1'b0;
      w_ok_ff       <= 1'b0;
      awaddr_ff     <= 12'h0;
      wdata_ff      <= 32'h0;
      ctrl_ff       <= `MBS_RST_CTRL;
      privileged_client_address_ff <= 32'h0;
      timeout_ff    <= `MBS_RST_TIMEOUT;
      unit_ff       <= `MBS_RST_UNIT;
      n_ff          <= `MBS_RST_N;
      m_ff          <= `MBS_RST_M;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awaddr_ff)
          `MBS_REG_CTRL:      ctrl_ff <= wdata_ff[1:0]; // RULE_16
          `MBS_REG_PRIV_ADDR: privileged_client_address_ff <= wdata_ff;
          `MBS_REG_TIMEOUT:   timeout_ff <= wdata_ff[15:0]; // RULE_02
          `MBS_REG_UNIT:      unit_ff <= wdata_ff[7:0];
          `MBS_REG_COUNTS: begin
            n_ff <= (wdata_ff[7:0] > `MBS_MAX_WORDS) ? 8'hf0 : wdata_ff[7:0]; // RULE_06
            m_ff <= (wdata_ff[15:8] > `MBS_MAX_WORDS) ? 8'hf0 : wdata_ff[15:8]; // RULE_07
          end
          `MBS_REG_STATUS, `MBS_REG_PORT: s_axi_bresp <= 2'h0;
          default:            s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `MBS_REG_CTRL:      s_axi_rdata <= {30'h0, ctrl_ff};
          `MBS_REG_PRIV_ADDR: s_axi_rdata <= privileged_client_address_ff;
          `MBS_REG_TIMEOUT:   s_axi_rdata <= {16'h0, timeout_ff};
          `MBS_REG_UNIT:      s_axi_rdata <= {24'h0, unit_ff};
          `MBS_REG_COUNTS:    s_axi_rdata <= {16'h0, m_ff, n_ff};
          `MBS_REG_STATUS:    s_axi_rdata <= {15'h0, privileged_client_lost_flag_ff,
                                              to_cnt_ff};
          `MBS_REG_PORT:      s_axi_rdata <= {16'h0, `MBS_PORT};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // Snapshot of both arrays; one edge swaps all words at once
  reg  [3839:0] read_snap_ff;
  reg  [3839:0] written_work_ff;
  wire          snap_tick = tick_sel ? main_task_tick : parent_tick; // RULE_16
  always @(posedge aclk) begin
    if (!aresetn) begin
      read_snap_ff         <= 3840'h0;
      app_written_words_ff <= 3840'h0;
    end else if (snap_tick) begin
      read_snap_ff         <= app_read_words; // RULE_15
      app_written_words_ff <= written_work_ff; // RULE_15
    end
  end
  // ==========================================================
  // Request decode
  wire        enable  = ctrl_ff[`MBS_CTRL_ENABLE];
  wire        is_priv = (privileged_client_address_ff != 32'h0) &&
                        (req_peer == privileged_client_address_ff); // RULE_03
  wire        for_us  = enable && (req_port == `MBS_PORT) && // RULE_04
                        (req_unit == unit_ff) && (req_unit != `MBS_UNIT_EMB); // RULE_05
  wire        to_emb  = (req_port == `MBS_PORT) && (req_unit == `MBS_UNIT_EMB); // RULE_05
  wire [8:0]  total   = {1'b0, n_ff} + {1'b0, m_ff};
  wire [8:0]  rd_end  = {1'b0, req_rd_addr} + {1'b0, req_rd_qty};
  wire [8:0]  wr_end  = {1'b0, req_wr_addr} + {1'b0, req_wr_qty};
  wire        fc_rd   = (req_func == `MBS_FC_RD);
  wire        fc_w1   = (req_func == `MBS_FC_WR1);
  wire        fc_wn   = (req_func == `MBS_FC_WRN);
  wire        fc_rw   = (req_func == `MBS_FC_RW);
  wire        fc_ok   = fc_rd || fc_w1 || fc_wn || fc_rw; // RULE_13
  wire        do_rd   = fc_rd || fc_rw;
  wire        do_wr   = fc_w1 || fc_wn || fc_rw;
  wire [7:0]  wqty    = fc_w1 ? 8'h01 : req_wr_qty;
  wire [8:0]  wend    = fc_w1 ? {1'b0, req_wr_addr} + 9'h001 : wr_end;
  wire        rd_bad  = do_rd && (req_rd_qty == 8'h0 || rd_end > total); // RULE_14
  // Writes beyond n would hit read-only words, also an address fault
  wire        wr_bad  = do_wr && (wqty == 8'h0 || wend > {1'b0, n_ff}); // RULE_11
  reg  [2:0]  st_ff;
  reg  [7:0]  ptr_ff;
  reg  [7:0]  left_ff;
  reg  [7:0]  rptr_ff;
  reg  [7:0]  rleft_ff;
  reg         rd_pend_ff;
  wire [15:0] rd_word = (rptr_ff < n_ff) ? written_work_ff[rptr_ff*W +: W] // RULE_08
                        : read_snap_ff[(rptr_ff - n_ff)*W +: W]; // RULE_09
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff             <= ST_IDLE;
      ptr_ff            <= 8'h0;
      left_ff           <= 8'h0;
      rptr_ff           <= 8'h0;
      rleft_ff          <= 8'h0;
      rd_pend_ff        <= 1'b0;
      written_work_ff   <= 3840'h0;
      rsp_valid_ff      <= 1'b0;
      rsp_exc_ff        <= 1'b0;
      rsp_code_ff       <= 8'h0;
      rsp_word_valid_ff <= 1'b0;
      rsp_word_ff       <= 16'h0;
      rsp_done_ff       <= 1'b0;
      emb_route_ff      <= 1'b0;
    end else begin
      rsp_valid_ff      <= 1'b0;
      rsp_word_valid_ff <= 1'b0;
      rsp_done_ff       <= 1'b0;
      emb_route_ff      <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (req_valid && to_emb)
            emb_route_ff <= 1'b1; // RULE_05
          else if (req_valid && for_us) begin
            rsp_valid_ff <= 1'b1;
            rsp_code_ff  <= req_func;
            rsp_exc_ff   <= 1'b0;
            if (!fc_ok) begin
              rsp_exc_ff  <= 1'b1; // RULE_20
              rsp_code_ff <= `MBS_EX_FUNC; // RULE_20
              rsp_done_ff <= 1'b1;
            end else if (rd_bad || wr_bad) begin
              rsp_exc_ff  <= 1'b1; // RULE_14
              rsp_code_ff <= `MBS_EX_ADDR; // RULE_14
              rsp_done_ff <= 1'b1;
            end else begin
              ptr_ff     <= req_wr_addr;
              left_ff    <= wqty;
              rptr_ff    <= req_rd_addr;
              rleft_ff   <= req_rd_qty;
              rd_pend_ff <= do_rd;
              st_ff      <= do_wr ? ST_WR : ST_RD; // RULE_12
            end
          end
        end
        ST_WR: begin
          // One word per req_valid beat; front end supplies words in order
          if (req_valid) begin
            written_work_ff[ptr_ff*W +: W] <= req_wr_data; // RULE_11
            ptr_ff  <= ptr_ff + 8'h01;
            left_ff <= left_ff - 8'h01;
            if (left_ff == 8'h01) begin
              if (rd_pend_ff)
                st_ff <= ST_RD; // RULE_12
              else begin
                rsp_done_ff <= 1'b1;
                st_ff       <= ST_IDLE;
              end
            end
          end
        end
        ST_RD: begin
          rsp_word_valid_ff <= 1'b1;
          rsp_word_ff       <= rd_word; // RULE_10
          rptr_ff           <= rptr_ff + 8'h01;
          rleft_ff          <= rleft_ff - 8'h01;
          if (rleft_ff == 8'h01) begin
            rsp_done_ff <= 1'b1;
            st_ff       <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Privileged client supervision
  wire priv_seen = req_valid && (st_ff == ST_IDLE) && for_us && is_priv; // RULE_19
  wire unit_tick;
  mbs_tick_div #(
    .DIV (TO_DIV)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (priv_seen),
    .tick_ff (unit_tick)
  );
  always @(posedge aclk) begin
    if (!aresetn) begin
      to_cnt_ff <= 16'h0;
      privileged_client_lost_flag_ff <= 1'b0;
    end else if (privileged_client_address_ff == 32'h0) begin
      to_cnt_ff <= 16'h0; // RULE_03
      privileged_client_lost_flag_ff <= 1'b0;
    end else if (priv_seen) begin
      to_cnt_ff <= 16'h0; // RULE_19
      privileged_client_lost_flag_ff <= 1'b0; // RULE_19
    end else if (unit_tick && timeout_ff != 16'h0) begin
      if (to_cnt_ff + 16'h1 >= timeout_ff)
        privileged_client_lost_flag_ff <= 1'b1; // RULE_17
      else
        to_cnt_ff <= to_cnt_ff + 16'h1;
    end
  end
  // ==========================================================
  // Connection reclaim: only when at or over the limit, never the privileged peer
  always @(posedge aclk) begin
    if (!aresetn)
      conn_close_ff <= 1'b0;
    else
      conn_close_ff <= conn_reclaim && (conn_active >= `MBS_MAX_CONN) && // RULE_18
                       !(privileged_client_address_ff != 32'h0 &&
                         conn_peer == privileged_client_address_ff); // RULE_01
  end
endmodule
`default_nettype wire

// ---- verif/mbs_checker.sv ----
// Checker: timing relations on the register server ports.
// Assumes unit id left at its reset value 1 while requests run.
`default_nettype none
module mbs_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Request
  input wire logic        req_valid,
  input wire logic [15:0] req_port,
  input wire logic [7:0]  req_unit,
  input wire logic [7:0]  req_func,
  // Answer
  input wire logic        rsp_valid_ff,
  input wire logic        rsp_exc_ff,
  input wire logic [7:0]  rsp_code_ff,
  input wire logic        rsp_word_valid_ff,
  input wire logic        rsp_done_ff,
  input wire logic        emb_route_ff,
  // Status
  input wire logic        conn_reclaim,
  input wire logic        conn_close_ff,
  input wire logic        privileged_client_lost_flag_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PORT = 16'h01f6;
  localparam logic [7:0]  UNIT = 8'h01;
  localparam logic [7:0]  EMB  = 8'hff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Busy from answer header to done; write words are not headers
  logic busy_ff;
  always_ff @(posedge aclk)
    if (!aresetn) busy_ff <= 1'b0;
    else if (rsp_done_ff) busy_ff <= 1'b0;
    else if (rsp_valid_ff) busy_ff <= 1'b1;
  sequence s_hdr;
    req_valid && !busy_ff && req_port == PORT && req_unit == UNIT;
  endsequence
  sequence s_unsup;
    s_hdr ##0 !(req_func inside {8'h03, 8'h06, 8'h10, 8'h17});
  endsequence
  // ==========================================================
  // Assertions
  port_filter_a: assert property (
    req_valid && !busy_ff && req_port != PORT |=> !rsp_valid_ff)
    else $error("foreign port answered");
  unit_answer_a: assert property (
    s_hdr |=> rsp_valid_ff)
    else $error("own unit not answered");
  emb_route_a: assert property (
    req_valid && !busy_ff && req_port == PORT && req_unit == EMB
    |=> !rsp_valid_ff ##[0:1] emb_route_ff)
    else $error("unit 255 not routed out");
  exc_shape_a: assert property (
    rsp_valid_ff && rsp_exc_ff |-> rsp_done_ff && !rsp_word_valid_ff
      && (rsp_code_ff == 8'h01 || rsp_code_ff == 8'h02))
    else $error("bad exception");
  unsup_func_a: assert property (
    s_unsup |=> rsp_valid_ff && rsp_exc_ff && rsp_code_ff == 8'h01)
    else $error("unsupported not refused");
  func_echo_a: assert property (
    rsp_valid_ff && !rsp_exc_ff |-> rsp_code_ff inside {8'h03, 8'h06, 8'h10, 8'h17})
    else $error("bad function echoed");
  read_words_a: assert property (
    rsp_valid_ff && !rsp_exc_ff && rsp_code_ff == 8'h03 |=> rsp_word_valid_ff)
    else $error("read without words");
  close_cause_a: assert property (
    conn_close_ff |-> $past(conn_reclaim))
    else $error("close without reclaim");
  lost_clear_a: assert property (
    $fell(privileged_client_lost_flag_ff) |-> $past(req_valid) || $past(req_valid, 2))
    else $error("lost cleared without request");
endmodule
bind mbs_server mbs_checker mbs_checker_inst (.*);
`default_nettype wire

// ---- verif/mbs_client.sv ----
// Client model: remote scanner issuing parsed requests.
// Assumes caller sits just after a clock edge; unit id stays 1.
`default_nettype none
module mbs_client (
  // Clock
  input wire logic        aclk,
  // Request
  output var logic        req_valid,
  output var logic [15:0] req_port,
  output var logic [7:0]  req_unit,
  output var logic [31:0] req_peer,
  output var logic [7:0]  req_func,
  output var logic [7:0]  req_rd_addr,
  output var logic [7:0]  req_rd_qty,
  output var logic [7:0]  req_wr_addr,
  output var logic [7:0]  req_wr_qty,
  output var logic [15:0] req_wr_data,
  // Answer
  input wire logic        rsp_valid_ff,
  input wire logic        rsp_exc_ff,
  input wire logic [7:0]  rsp_code_ff,
  input wire logic        rsp_word_valid_ff,
  input wire logic [15:0] rsp_word_ff,
  input wire logic        rsp_done_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wd [0:7];
  logic [15:0] rw [0:7];
  logic        exc;
  logic [7:0]  code;
  int          nw;
  initial {req_valid, req_port, req_unit, req_peer, req_func, req_rd_addr} = '0;
  initial {req_rd_qty, req_wr_addr, req_wr_qty, req_wr_data} = '0;
  // ==========================================================
  // One transaction; idle fields inverted so stale values never match
  task automatic xfer(input logic [15:0] p, input logic [7:0] u, input logic [31:0] pe,
                      input logic [7:0] f, ra, rq, wa, wq);
    int i;
    @(posedge aclk);
    req_valid <= 1'b1;
    {req_port, req_unit, req_peer, req_func} <= {p, u, pe, f};
    {req_rd_addr, req_rd_qty, req_wr_addr, req_wr_qty} <= {ra, rq, wa, wq};
    @(posedge aclk);
    req_valid <= 1'b0;
    {req_port, req_unit, req_peer, req_func} <= ~{p, u, pe, f};
    nw = 0;
    exc = 1'b0;
    code = 8'h00;
    i = 0;
    if (p != 16'h01f6 || u != 8'h01) return;
    do @(posedge aclk); while (!rsp_valid_ff);
    exc = rsp_exc_ff;
    code = rsp_code_ff;
    while (!rsp_done_ff) begin
      req_valid <= (i < wq);
      req_wr_data <= wd[i[2:0]];
      i++;
      @(posedge aclk);
      if (rsp_word_valid_ff) begin
        rw[nw[2:0]] = rsp_word_ff;
        nw++;
      end
    end
    req_valid <= 1'b0;
    req_wr_data <= ~req_wr_data;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench: AXI4-Lite setup, client traffic, application ticks.
// Assumes the server built with a 10-cycle timeout unit.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic          aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic          s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]   s_axi_wdata = '0, s_axi_rdata, req_peer, conn_peer = '0, rd;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
  logic          req_valid, rsp_valid_ff, rsp_exc_ff, rsp_word_valid_ff, rsp_done_ff;
  logic [15:0]   req_port, req_wr_data, rsp_word_ff;
  logic [7:0]    req_unit, req_func, req_rd_addr, req_rd_qty, req_wr_addr, req_wr_qty;
  logic [7:0]    rsp_code_ff;
  logic          emb_route_ff, conn_reclaim = 1'b0, conn_close_ff;
  logic          parent_tick = 1'b0, main_task_tick = 1'b0, privileged_client_lost_flag_ff;
  logic [3:0]    conn_active = '0;
  logic [3839:0] app_read_words = '0, app_written_words_ff;
  logic [31:0]   peer = 32'h0a000009;
  int            errors = 0, total_checks = 0, cyc = 0, hdrs = 0, embs = 0;
  localparam logic [31:0] PRIV = 32'h0a000002;
  mbs_server #(.TO_DIV(10)) mbs_server_inst (.s_axi_wstrb(4'hf), .*);
  mbs_client mbs_client_inst (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    hdrs <= hdrs + int'(rsp_valid_ff);
    embs <= embs + int'(emb_route_ff);
    if (cyc == 6000) begin
      errors++;
      print_verdict;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic mb(input logic [7:0] f, ra, rq, wa, wq);
    mbs_client_inst.xfer(16'h01f6, 8'h01, peer, f, ra, rq, wa, wq);
  endtask
  task automatic tick(input logic main);
    {main_task_tick, parent_tick} <= {main, !main};
    @(posedge aclk);
    {main_task_tick, parent_tick} <= 2'h0;
    @(posedge aclk);
  endtask
  function automatic logic [31:0] ans();
    return {mbs_client_inst.exc, mbs_client_inst.code};
  endfunction
  function automatic logic [15:0] rw(input int i);
    return mbs_client_inst.rw[i];
  endfunction
  function automatic logic [15:0] aw(input int i);
    return app_written_words_ff[i*16 +: 16];
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdr(12'h000); chk("ctrl", rd, 32'h2);
    rdr(12'h00c); chk("unit", rd, 32'h1);
    rdr(12'h010); chk("counts", rd, 32'hf0f0);
    rdr(12'h008); chk("timeout", rd, 32'ha);
    wr(12'h018, 32'h0);
    rdr(12'h018); chk("port", rd, 32'h1f6);
    wr(12'h040, 32'h0); chk("wr bad", rr, 2'h2);
    rdr(12'h040); chk("unmapped", rd, 32'h0); chk("rd bad", rr, 2'h2);
  endtask
  task automatic t_map;
    {mbs_client_inst.wd[0], mbs_client_inst.wd[1]} = 32'h12345678;
    mb(8'h10, 0, 0, 8'd238, 2); chk("fc16", ans(), 32'h010);
    chk("w238 pre", aw(238), 16'h0);
    app_read_words[31:0] <= 32'h0bb20aa1;
    tick(1'b0);
    chk("w238", aw(238), 16'h1234);
    chk("w239", aw(239), 16'h5678);
    app_read_words[31:0] <= 32'h0dd40cc3;
    mb(8'h03, 8'd238, 4, 0, 0); chk("fc3", ans(), 32'h003);
    chk("rd", {rw(0), rw(1)}, 32'h12345678);
    chk("snap", {rw(2), rw(3)}, 32'h0aa10bb2);
  endtask
  task automatic t_write;
    mbs_client_inst.wd[0] = 16'h00ff;
    mb(8'h06, 0, 0, 8'd240, 1); chk("fc6 ro", ans(), 32'h102);
    mb(8'h10, 0, 0, 8'd239, 2); chk("fc16 past n", ans(), 32'h102);
    mb(8'h06, 0, 0, 8'd5, 1); chk("fc6", ans(), 32'h006);
    tick(1'b0);
    chk("w239 kept", aw(239), 16'h5678);
    chk("w5", aw(5), 16'h00ff);
    mbs_client_inst.wd[0] = 16'h4321;
    mb(8'h17, 8'd5, 2, 8'd6, 1); chk("fc23", ans(), 32'h017);
    chk("fc23 rd", {rw(0), rw(1)}, 32'h00ff4321);
  endtask
  task automatic t_range;
    wr(12'h010, 32'h0a0a);
    mb(8'h03, 8'd19, 1, 0, 0); chk("top", ans(), 32'h003);
    mb(8'h03, 8'd19, 2, 0, 0); chk("above", ans(), 32'h102);
    mb(8'h03, 8'd0, 0, 0, 0); chk("qty0", ans(), 32'h102);
    wr(12'h010, 32'hf0f0);
  endtask
  task automatic t_unsup;
    logic [7:0] fl [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h0f, 8'h2b};
    mbs_client_inst.wd[0] = 16'hdead;
    foreach (fl[k]) begin
      mb(fl[k], 5, 1, 5, 1); chk("unsup", ans(), 32'h101);
      tick(1'b0);
      chk("w5 kept", aw(5), 16'h00ff);
    end
  endtask
  task automatic t_route;
    int h = hdrs, e = embs;
    mbs_client_inst.xfer(16'h01f7, 8'h01, peer, 8'h03, 0, 1, 0, 0);
    mbs_client_inst.xfer(16'h01f6, 8'h02, peer, 8'h03, 0, 1, 0, 0);
    mbs_client_inst.xfer(16'h01f6, 8'hff, peer, 8'h03, 0, 1, 0, 0);
    repeat (4) @(posedge aclk);
    chk("headers", hdrs, h);
    chk("embedded", embs, e + 1);
  endtask
  task automatic t_tick;
    wr(12'h000, 32'h3);
    app_read_words[15:0] <= 16'h0ee5;
    tick(1'b0);
    mb(8'h03, 8'd240, 1, 0, 0); chk("parent off", rw(0), 16'h0cc3);
    tick(1'b1);
    mb(8'h03, 8'd240, 1, 0, 0); chk("main", rw(0), 16'h0ee5);
    wr(12'h000, 32'h2);
  endtask
  task automatic t_lost;
    repeat (60) @(posedge aclk);
    chk("no supervision", privileged_client_lost_flag_ff, 0);
    wr(12'h004, PRIV);
    wr(12'h008, 32'h3);
    peer = PRIV;
    mb(8'h03, 0, 1, 0, 0);
    repeat (10) @(posedge aclk);
    chk("early", privileged_client_lost_flag_ff, 0);
    repeat (35) @(posedge aclk);
    chk("lost", privileged_client_lost_flag_ff, 1);
    peer = 32'h0a000009;
    mb(8'h03, 0, 1, 0, 0);
    chk("other peer", privileged_client_lost_flag_ff, 1);
    peer = PRIV;
    mb(8'h03, 0, 1, 0, 0);
    repeat (2) @(posedge aclk);
    chk("regained", privileged_client_lost_flag_ff, 0);
  endtask
  task automatic t_conn;
    {conn_active, conn_peer, conn_reclaim} <= {4'h9, PRIV, 1'b1};
    repeat (2) @(posedge aclk);
    chk("keep priv", conn_close_ff, 0);
    conn_peer <= 32'h0a000009;
    repeat (2) @(posedge aclk);
    chk("close other", conn_close_ff, 1);
    conn_reclaim <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_map;
    t_write;
    t_range;
    t_unsup;
    t_route;
    t_tick;
    t_lost;
    t_conn;
    print_verdict;
  end
endmodule
`default_nettype wire
